/* File: rtl/system_reset_stop_wait_sequencer.sv */
// reset sequencing, interrupt arbitration, break and low-power control
`timescale 1ns/1ps
`include "sys_seq_params.svh"
module system_reset_stop_wait_sequencer #(
  parameter int NUM_IRQ = 8,
  parameter int LONG_RESET = `LONG_RESET_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // reset sources, asynchronous
  input wire logic power_on_pulse,
  input wire logic low_voltage_trip,
  input wire logic watchdog_reset,
  // reset sources from core logic
  input wire logic illegal_opcode,
  input wire logic illegal_address,
  input wire logic monitor_entry_reset,
  // open-drain reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic core_reset,
  // option bits
  input wire logic short_recovery_option,
  input wire logic emulation_mode,
  // core handshake
  input wire logic instr_done,
  input wire logic mask_bit,
  input wire logic software_interrupt,
  input wire logic return_from_interrupt,
  input wire logic idle_exec,
  input wire logic halt_exec,
  input wire logic int_serviced,
  // interrupt sources
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic break_req,
  output sys_seq_pkg::int_ctrl_type int_ctrl,
  output sys_seq_pkg::clk_ctrl_type clk_ctrl,
  output logic break_state,
  output logic flag_clear_allow,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  localparam int CW = `COUNT_W;
  localparam logic [CW-1:0] LONG_END = CW'(LONG_RESET - 1);
  localparam logic [CW-1:0] PIN_END = CW'(`PIN_LOW_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_END = CW'(`HOLD_CYCLES - 1);
  localparam logic [CW-1:0] REC_LONG_END = CW'(`REC_LONG_CYCLES - 1);
  localparam logic [CW-1:0] REC_SHORT_END = CW'(`REC_SHORT_CYCLES - 1);

  generate
    if (LONG_RESET + `HOLD_CYCLES >= (1 << CW) || LONG_RESET < 1) begin : g_bad_long
      $error("long reset count does not fit the counter");
    end
    if (NUM_IRQ < 1 || NUM_IRQ > 15) begin : g_bad_irq
      $error("interrupt count must be 1 to 15");
    end
  endgenerate

  // two-flop synchronisers for asynchronous inputs
  logic [3:0] async_in;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  assign async_in = {power_on_pulse, low_voltage_trip, watchdog_reset, ~reset_pin_in};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  logic por_s;
  logic low_volt_s;
  logic wdog_s;
  logic pin_low_s;
  assign por_s = sync_b[3];
  assign low_volt_s = sync_b[2];
  assign wdog_s = sync_b[1];
  assign pin_low_s = sync_b[0];

  sys_seq_pkg::seq_state_type state;
  logic [CW-1:0] rec_count;
  logic long_reset;
  logic driving_pin;

  // internal sources, all equal: any of them restarts the sequence
  logic long_src;
  logic short_src;
  logic internal_reset;
  assign long_src = por_s | low_volt_s;
  assign short_src = wdog_s | illegal_opcode | illegal_address | monitor_entry_reset; // R4
  assign internal_reset = long_src | short_src; // R16

  // pending enabled hardware interrupts, lowest index wins
  logic [NUM_IRQ-1:0] pend;
  logic any_pend;
  logic [3:0] best;
  assign pend = irq_req & irq_enable; // R12
  assign any_pend = |pend;

  always_comb begin
    best = 4'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        best = 4'(i + 1); // R13
      end
    end
  end

  logic [CW-1:0] rec_end;
  assign rec_end = short_recovery_option ? REC_SHORT_END : REC_LONG_END; // R7

  logic wake;
  assign wake = any_pend | break_req | pin_low_s;

  // sequencer state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= sys_seq_pkg::reset_long;
      long_reset <= 1'b1;
    end else if (internal_reset) begin
      state <= long_src ? sys_seq_pkg::reset_long : sys_seq_pkg::reset_pin_drive; // R3
      long_reset <= long_src;
    end else begin
      unique case (state)
        sys_seq_pkg::reset_long: begin
          if (rec_count == LONG_END) begin
            state <= sys_seq_pkg::reset_hold; // R1
          end
        end
        sys_seq_pkg::reset_pin_drive: begin
          if (rec_count == PIN_END) begin
            state <= sys_seq_pkg::reset_hold;
          end
        end
        sys_seq_pkg::reset_hold: begin
          if (rec_count == (long_reset ? LONG_END + HOLD_END + 13'h0001 :
                            PIN_END + HOLD_END + 13'h0001)) begin
            state <= sys_seq_pkg::run; // R2
          end
        end
        sys_seq_pkg::ext_reset: begin
          if (!pin_low_s) begin
            state <= sys_seq_pkg::run;
          end
        end
        sys_seq_pkg::run: begin
          if (pin_low_s) begin
            state <= sys_seq_pkg::ext_reset;
          end else if (halt_exec) begin
            state <= sys_seq_pkg::deep_halt;
          end else if (idle_exec) begin
            state <= sys_seq_pkg::idle;
          end
        end
        sys_seq_pkg::idle: begin
          if (pin_low_s) begin
            state <= sys_seq_pkg::ext_reset; // R22
          end else if (any_pend || (break_req && emulation_mode)) begin
            state <= sys_seq_pkg::run; // R21
          end
        end
        sys_seq_pkg::deep_halt: begin
          if (wake) begin
            state <= sys_seq_pkg::recover;
          end
        end
        sys_seq_pkg::recover: begin
          if (rec_count == rec_end) begin
            state <= pin_low_s ? sys_seq_pkg::ext_reset : sys_seq_pkg::run; // R7
          end
        end
      endcase
    end
  end

  // recovery counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rec_count <= '0;
    end else if (internal_reset) begin
      rec_count <= '0;
    end else if (state == sys_seq_pkg::deep_halt || (state == sys_seq_pkg::run && halt_exec)) begin
      rec_count <= '0; // R6
    end else if (state == sys_seq_pkg::recover && rec_count == rec_end) begin
      rec_count <= rec_count + 13'h0001;
    end else begin
      // free-running in every other state, external reset included
      rec_count <= rec_count + 13'h0001; // R5 R8 R9
    end
  end

  // open-drain pin and core reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      driving_pin <= 1'b1;
      core_reset <= 1'b1;
    end else begin
      driving_pin <= internal_reset || (state == sys_seq_pkg::reset_long) ||
                     (state == sys_seq_pkg::reset_pin_drive && rec_count != PIN_END) ||
                     (state == sys_seq_pkg::reset_long && rec_count == LONG_END); // R1 R3
      core_reset <= internal_reset || (state == sys_seq_pkg::reset_long) ||
                    (state == sys_seq_pkg::reset_pin_drive) ||
                    (state == sys_seq_pkg::reset_hold) ||
                    (state == sys_seq_pkg::ext_reset) ||
                    (state == sys_seq_pkg::run && pin_low_s); // R2
    end
  end
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = driving_pin;

  // clock divider and gating
  logic [1:0] phase;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  logic clocks_off;
  logic core_off;
  assign clocks_off = (state == sys_seq_pkg::deep_halt) || (state == sys_seq_pkg::recover) ||
                      (state == sys_seq_pkg::reset_long);
  assign core_off = clocks_off || (state == sys_seq_pkg::idle);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clk_ctrl <= '0;
    end else begin
      clk_ctrl.osc_clock_x4_on <= state != sys_seq_pkg::deep_halt; // R6
      clk_ctrl.osc_clock_x2_on <= state != sys_seq_pkg::deep_halt; // R6
      clk_ctrl.core_clk_on <= !core_off; // R21
      clk_ctrl.periph_clk_on <= !clocks_off;
      clk_ctrl.bus_tick <= !clocks_off && phase == 2'h3; // R23
    end
  end

  // interrupt latch and arbitration
  logic latched;
  logic [3:0] latched_vec;
  logic boundary;
  logic hw_take;
  logic brk_take;
  assign boundary = (state == sys_seq_pkg::run) && instr_done;
  assign brk_take = break_req && !break_state &&
                    (boundary || (state == sys_seq_pkg::idle && emulation_mode)); // R17 R22
  assign hw_take = !latched && !brk_take && any_pend && !mask_bit &&
                   (boundary || (state == sys_seq_pkg::idle) ||
                    (state == sys_seq_pkg::recover && rec_count == rec_end)); // R12 R21 R7

  always_ff @(posedge mclk) begin
    if (!rst_n || core_reset) begin
      latched <= 1'b0;
      latched_vec <= 4'h0;
    end else if (int_serviced || (latched && !mask_bit && !int_ctrl.take)) begin
      latched <= 1'b0; // R11
    end else if (hw_take) begin
      latched <= 1'b1;
      latched_vec <= best; // R11
    end
  end

  logic soft_take;
  assign soft_take = boundary && software_interrupt; // R15

  always_ff @(posedge mclk) begin
    if (!rst_n || core_reset) begin
      int_ctrl <= '0;
    end else begin
      int_ctrl.take <= hw_take || brk_take || soft_take;
      int_ctrl.vector <= (brk_take || soft_take) ? `SOFT_INT_VECTOR :
                         (hw_take ? best : latched_vec); // R11 R17
      int_ctrl.stack_pc_minus1 <= hw_take && !brk_take && !soft_take; // R15
      int_ctrl.push_upper_index <= 1'b0; // R14
      int_ctrl.set_mask <= hw_take || brk_take || soft_take; // R10
      int_ctrl.clear_mask <= (state == sys_seq_pkg::run) && (idle_exec || halt_exec); // R20
      int_ctrl.unstack <= boundary && return_from_interrupt; // R10
    end
  end

  // break state and flag protection
  logic break_flag_clear_enable;
  always_ff @(posedge mclk) begin
    if (!rst_n || core_reset) begin
      break_state <= 1'b0;
    end else if (brk_take) begin
      break_state <= 1'b1; // R17
    end else if (boundary && return_from_interrupt) begin
      break_state <= 1'b0;
    end
  end

  // protection covers the second step of two-step clears alike
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_clear_allow <= 1'b1;
    end else begin
      flag_clear_allow <= !break_state || break_flag_clear_enable; // R18 R19
    end
  end

  // registers
  logic idle_exit_flag;
  sys_seq_pkg::reset_flags_type rsr;
  logic rd_break;
  logic rd_rsr;
  logic wr_break;
  logic wr_ctrl;
  assign rd_break = reg_rd && reg_addr == `OFS_BREAK_STATUS;
  assign rd_rsr = reg_rd && reg_addr == `OFS_RESET_STATUS;
  assign wr_break = reg_wr && reg_addr == `OFS_BREAK_STATUS;
  assign wr_ctrl = reg_wr && reg_addr == `OFS_BREAK_CONTROL;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      break_flag_clear_enable <= 1'b0;
    end else if (wr_ctrl) begin
      break_flag_clear_enable <= reg_wdata[`BIT_CLEAR_ENABLE];
    end
  end

  // set wins over a write of zero in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n || internal_reset) begin
      idle_exit_flag <= 1'b0;
    end else if (state == sys_seq_pkg::idle && break_req && emulation_mode) begin
      idle_exit_flag <= 1'b1; // R22
    end else if (wr_break && !reg_wdata[`BIT_IDLE_EXIT]) begin
      idle_exit_flag <= 1'b0;
    end
  end

  logic pin_flag_ok;
  assign pin_flag_ok = pin_low_s && !internal_reset && state == sys_seq_pkg::run;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rsr <= `RESET_STATUS_INIT;
    end else if (por_s) begin
      rsr <= `RESET_STATUS_INIT; // R24
    end else begin
      rsr.power_on <= rsr.power_on && !rd_rsr; // R24
      rsr.pin <= pin_flag_ok || (rsr.pin && !rd_rsr);
      rsr.watchdog <= wdog_s || (rsr.watchdog && !rd_rsr);
      rsr.illegal_op <= illegal_opcode || (rsr.illegal_op && !rd_rsr);
      rsr.illegal_addr <= illegal_address || (rsr.illegal_addr && !rd_rsr);
      rsr.monitor_entry <= monitor_entry_reset || (rsr.monitor_entry && !rd_rsr); // R4
      rsr.low_voltage <= low_volt_s || (rsr.low_voltage && !rd_rsr); // R1
      rsr.unused <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_break) begin
      reg_rdata <= {6'h00, idle_exit_flag, 1'b0};
    end else if (rd_rsr) begin
      reg_rdata <= rsr;
    end else if (reg_rd && reg_addr == `OFS_BREAK_CONTROL) begin
      reg_rdata <= {break_flag_clear_enable, 7'h00};
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

/* File: inc/sys_seq_params.svh */
// constants for the reset, interrupt and low-power sequencer
// Functional notes
// R1: low voltage sets flag, pin low 4096+32
// R2: then 32 more cycles before core release
// R3: every internal reset drives pin low
// R4: monitor entry reset input causes internal reset
// R5: recovery counter is thirteen bits wide
// R6: deep halt clears counter, gates both clocks
// R7: deep halt recovery 32 or 4096 cycles
// R8: external pin reset leaves counter unchanged; the counter keeps counting in ext_reset
// R9: counter free-runs after every reset state
// R10: entry sets mask; return restores registers
// R11: latched interrupt holds until serviced; the latch also clears when mask_bit is clear and no take is issued
// R12: take at boundary if unmasked and enabled
// R13: highest priority first; pending taken after return
// R14: upper index register never pushed
// R15: software interrupt ignores mask, stacks pc
// R16: resets share top priority, no arbitration
// R17: break forces software interrupt vector
// R18: break protects flags unless clear enabled
// R19: two-step flags protected likewise during break
// R20: idle or deep halt clears interrupt mask
// R21: idle stops core clock; wake stacks next cycle
// R22: idle exits on reset or break; flag set
// R23: bus clock is oscillator divided by four
// R24: status read clears; power-on sets only its flag
`ifndef SYS_SEQ_PARAMS_SVH
`define SYS_SEQ_PARAMS_SVH
`define OFS_BREAK_STATUS 8'h00
`define OFS_RESET_STATUS 8'h01
`define OFS_BREAK_CONTROL 8'h03
`define BIT_IDLE_EXIT 1
`define BIT_CLEAR_ENABLE 7
`define RESET_STATUS_INIT 8'h80
`define LONG_RESET_CYCLES 4128
`define PIN_LOW_CYCLES 32
`define HOLD_CYCLES 32
`define REC_LONG_CYCLES 4096
`define REC_SHORT_CYCLES 32
`define SOFT_INT_VECTOR 4'h0
`define COUNT_W 13
`endif

/* File: inc/sys_seq_pkg.sv */
// types for the reset, interrupt and low-power sequencer
package sys_seq_pkg;
  typedef enum logic [2:0] {
    reset_long,
    reset_pin_drive,
    reset_hold,
    ext_reset,
    run,
    idle,
    deep_halt,
    recover
  } seq_state_type;

  // reset source flags in status register bit order 7..0
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic illegal_op;
    logic illegal_addr;
    logic monitor_entry;
    logic low_voltage;
    logic unused;
  } reset_flags_type;

  // exception control toward the core
  typedef struct packed {
    logic take;
    logic [3:0] vector;
    logic stack_pc_minus1;
    logic push_upper_index;
    logic set_mask;
    logic clear_mask;
    logic unstack;
  } int_ctrl_type;

  // clock control toward core and peripherals
  typedef struct packed {
    logic osc_clock_x4_on;
    logic osc_clock_x2_on;
    logic core_clk_on;
    logic periph_clk_on;
    logic bus_tick;
  } clk_ctrl_type;
endpackage

/* File: verif/seq_chk.sv */
// port assertions for the reset, interrupt and low-power sequencer
`timescale 1ns/1ps
module seq_chk #(
  parameter int LONG_RESET = 4128
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // watched ports
  input wire logic halt_exec,
  input wire logic reg_rd,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic core_reset,
  input sys_seq_pkg::int_ctrl_type int_ctrl,
  input sys_seq_pkg::clk_ctrl_type clk_ctrl,
  input wire logic [7:0] reg_rdata
);
  int oe_cnt;
  int hold_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oe_cnt <= 0;
      hold_cnt <= 0;
    end else begin
      oe_cnt <= reset_pin_oe ? oe_cnt + 1 : 0;
      hold_cnt <= reset_pin_oe ? 0 : hold_cnt + 1;
    end
  end
  pin_low_a: assert property (reset_pin_out == 1'b0)
    else $error("pin driven high");
  core_held_a: assert property (reset_pin_oe |-> core_reset)
    else $error("core free while pin low");
  pin_time_a: assert property ($fell(reset_pin_oe) |->
    oe_cnt inside {[31:34]} || oe_cnt >= LONG_RESET) else $error("pin time");
  hold_time_a: assert property ($fell(core_reset) && hold_cnt < 40 |->
    hold_cnt inside {[30:34]}) else $error("hold time");
  upper_index_a: assert property (int_ctrl.take |-> !int_ctrl.push_upper_index)
    else $error("upper index pushed");
  take_mask_a: assert property (int_ctrl.take |-> int_ctrl.set_mask)
    else $error("mask not set");
  pc_adjust_a: assert property (int_ctrl.take |->
    int_ctrl.stack_pc_minus1 == (int_ctrl.vector != 4'h0)) else $error("pc adjust");
  clear_mask_a: assert property (halt_exec && !core_reset |=> int_ctrl.clear_mask)
    else $error("mask not cleared");
  halt_gate_a: assert property (halt_exec && !core_reset |-> ##[1:4]
    !clk_ctrl.osc_clock_x4_on && !clk_ctrl.osc_clock_x2_on) else $error("clocks run");
  bus_tick_a: assert property (clk_ctrl.bus_tick |=> !clk_ctrl.bus_tick [*3])
    else $error("tick spacing");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data stale");
  cover property (int_ctrl.take && int_ctrl.vector == 4'h0);
  cover property ($fell(clk_ctrl.osc_clock_x4_on));
  cover property ($fell(reset_pin_oe));
endmodule
bind system_reset_stop_wait_sequencer seq_chk #(.LONG_RESET(LONG_RESET)) i_chk (
  .mclk(mclk), .rst_n(rst_n), .halt_exec(halt_exec), .reg_rd(reg_rd),
  .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .core_reset(core_reset),
  .int_ctrl(int_ctrl), .clk_ctrl(clk_ctrl), .reg_rdata(reg_rdata));

/* File: verif/core_model.sv */
// core-side model: instruction boundaries, mask bit, handler entry and return
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // from the sequencer
  input wire logic core_reset,
  input wire logic core_clk_on,
  input sys_seq_pkg::int_ctrl_type int_ctrl,
  // op 1 soft interrupt, 2 idle, 3 halt; hold keeps the handler open
  input wire logic [1:0] op,
  input wire logic mask_force,
  input wire logic hold,
  // to the sequencer
  output logic instr_done,
  output logic mask_bit,
  output logic software_interrupt,
  output logic idle_exec,
  output logic halt_exec,
  output logic return_from_interrupt,
  output logic int_serviced
);
  logic [1:0] cnt;
  logic mask;
  logic in_isr;
  assign software_interrupt = instr_done && op == 2'h1;
  assign idle_exec = instr_done && op == 2'h2;
  assign halt_exec = instr_done && op == 2'h3;
  assign return_from_interrupt = instr_done && in_isr && !hold;
  assign mask_bit = mask | mask_force;
  always_ff @(posedge mclk) begin
    if (!rst_n || core_reset) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
      mask <= 1'b0;
      in_isr <= 1'b0;
      int_serviced <= 1'b0;
    end else begin
      cnt <= core_clk_on ? cnt + 2'h1 : cnt;
      instr_done <= core_clk_on && cnt == 2'h3;
      int_serviced <= int_ctrl.take;
      if (int_ctrl.take) begin
        in_isr <= 1'b1;
      end else if (return_from_interrupt) begin
        in_isr <= 1'b0;
      end
      if (int_ctrl.set_mask) begin
        mask <= 1'b1;
      end else if (int_ctrl.clear_mask || return_from_interrupt) begin
        mask <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/test_system_reset_stop_wait_sequencer.sv */
// testbench for the reset, interrupt and low-power sequencer
`timescale 1ns/1ps
module test_system_reset_stop_wait_sequencer;
  localparam int LR = 64;
  logic mclk, rst_n, pin_low, ssr, mforce, hold, brk, reg_wr, reg_rd, por, emu;
  logic [4:0] src;
  logic [1:0] op;
  logic [7:0] irq_req, irq_en, reg_addr, reg_wdata, reg_rdata, rd;
  logic lvt, wdg, ilop, ilad, mon, pin_in, pin_out, pin_oe, core_reset, bstate, fca;
  logic done, mask, sw_x, idle_x, halt_x, ret_x, svc;
  logic [7:0] flag [5] = '{8'h02, 8'h20, 8'h10, 8'h08, 8'h04};
  sys_seq_pkg::int_ctrl_type ic;
  sys_seq_pkg::clk_ctrl_type cc;
  int error_cnt = 0;
  int check_count = 0;
  int n, takes;
  assign {lvt, wdg, ilop, ilad, mon} = src;
  assign pin_in = pin_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  system_reset_stop_wait_sequencer #(.LONG_RESET(LR)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .power_on_pulse(por), .low_voltage_trip(lvt),
    .watchdog_reset(wdg), .illegal_opcode(ilop), .illegal_address(ilad),
    .monitor_entry_reset(mon), .reset_pin_in(pin_in), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .core_reset(core_reset), .short_recovery_option(ssr),
    .emulation_mode(emu), .instr_done(done), .mask_bit(mask), .software_interrupt(sw_x),
    .return_from_interrupt(ret_x), .idle_exec(idle_x), .halt_exec(halt_x), .int_serviced(svc),
    .irq_req(irq_req), .irq_enable(irq_en), .break_req(brk), .int_ctrl(ic),
    .clk_ctrl(cc), .break_state(bstate), .flag_clear_allow(fca), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  core_model i_core (.mclk(mclk), .rst_n(rst_n), .core_reset(core_reset),
    .core_clk_on(cc.core_clk_on), .int_ctrl(ic), .op(op), .mask_force(mforce),
    .hold(hold), .instr_done(done), .mask_bit(mask), .software_interrupt(sw_x),
    .idle_exec(idle_x), .halt_exec(halt_x), .return_from_interrupt(ret_x), .int_serviced(svc));
  always @(negedge mclk) begin
    if (ic.take === 1'b1) begin
      takes++;
    end
  end
  function automatic logic sig(input int k);
    case (k)
      0: return pin_oe;
      1: return !pin_oe;
      2: return !core_reset;
      3: return ic.take;
      4: return !cc.osc_clock_x4_on;
      5: return !cc.core_clk_on;
      6: return done;
      7: return bstate;
      default: return !bstate;
    endcase
  endfunction
  task finish_test();
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, m, got, exp);
    end
  endtask
  // counts cycles in n until condition k holds
  task wt(input int k, input int lim);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait %0d timed out", $time, k);
      finish_test();
    end
  endtask
  task rreg(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task do_op(input logic [1:0] o);
    op <= o;
    wt(6, 20);
    @(posedge mclk);
    op <= 2'h0;
    #1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {rst_n, pin_low, ssr, mforce, hold, brk, reg_wr, reg_rd} = 8'h00;
    {src, op} = 7'h00;
    {por, emu} = 2'h1;
    {irq_req, irq_en, reg_addr, reg_wdata} = 32'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    wt(1, LR + 20);
    chk(n >= LR && n <= LR + 3, 1'b1, "pin time");
    wt(2, 60);
    chk(n >= 30 && n <= 34, 1'b1, "hold time");
    rreg(8'h01);
    chk(rd, 8'h80, "power-on flag");
    rreg(8'h01);
    chk(rd, 8'h00, "read clear");
    rreg(8'h02);
    chk(rd, 8'h00, "unmapped");
    for (int i = 0; i < 5; i++) begin
      src <= 5'h10 >> i;
      wt(0, 20);
      src <= 5'h00;
      wt(1, LR + 20);
      chk(n >= (i == 0 ? LR : 29) && n <= (i == 0 ? LR + 3 : 34), 1'b1, "pin");
      wt(2, 60);
      chk(n >= 30 && n <= 34, 1'b1, "hold time");
      rreg(8'h01);
      chk(rd, flag[i], "source flag");
    end
    repeat (50) @(posedge mclk);
    pin_low <= 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    chk({core_reset, pin_oe}, 2'b10, "pin reset");
    pin_low <= 1'b0;
    wt(2, 40);
    rreg(8'h01);
    chk(rd, 8'h40, "pin flag");
    repeat (20) @(posedge mclk);
    takes = 0;
    irq_req <= 8'h24;
    repeat (20) @(posedge mclk);
    mforce <= 1'b1;
    irq_en <= 8'hff;
    repeat (20) @(posedge mclk);
    #1;
    chk(takes, 0, "masked or disabled");
    mforce <= 1'b0;
    wt(3, 20);
    chk({ic.vector, ic.stack_pc_minus1}, 5'h07, "first vector");
    irq_req <= 8'h20;
    @(posedge mclk);
    #1;
    wt(3, 40);
    chk(ic.vector, 4'h6, "pending after return");
    irq_req <= 8'h00;
    mforce <= 1'b1;
    do_op(2'h1);
    wt(3, 20);
    chk({ic.vector, ic.stack_pc_minus1}, 5'h00, "soft interrupt");
    mforce <= 1'b0;
    repeat (10) @(posedge mclk);
    for (int s = 1; s >= 0; s--) begin
      ssr <= s[0];
      do_op(2'h3);
      wt(4, 10);
      chk(cc.core_clk_on, 1'b0, "halt clocks");
      irq_req <= 8'h01;
      wt(3, 4200);
      chk(n >= (s ? 32 : 4096) && n <= (s ? 40 : 4110), 1'b1, "recovery");
      chk(ic.vector, 4'h1, "wake vector");
      irq_req <= 8'h00;
      repeat (10) @(posedge mclk);
    end
    for (int k = 0; k < 2; k++) begin
      hold <= (k == 1);
      do_op(2'h2);
      wt(5, 10);
      chk(cc.periph_clk_on, 1'b1, "periph clock");
      if (k == 0) begin
        irq_req <= 8'h02;
      end else begin
        {emu, brk} <= 2'b01;
        repeat (5) @(posedge mclk);
        #1;
        chk(cc.core_clk_on, 1'b0, "break without emulation");
        emu <= 1'b1;
      end
      wt(3, 20);
      chk({ic.vector, n <= 3}, k ? 5'h01 : 5'h05, "idle wake");
      irq_req <= 8'h00;
      brk <= 1'b0;
      repeat (10) @(posedge mclk);
    end
    wt(7, 10);
    chk(fca, 1'b0, "flags protected");
    rreg(8'h00);
    chk(rd, 8'h02, "idle exit flag");
    wreg(8'h03, 8'h80);
    repeat (2) @(posedge mclk);
    #1;
    chk(fca, 1'b1, "clear allowed");
    wreg(8'h00, 8'h00);
    rreg(8'h00);
    chk(rd, 8'h00, "flag cleared");
    rreg(8'h03);
    chk(rd, 8'h80, "clear enable");
    hold <= 1'b0;
    wt(8, 20);
    chk(bstate, 1'b0, "break left");
    por <= 1'b1;
    src <= 5'h04;
    wt(0, 20);
    {por, src} <= 6'h00;
    wt(2, LR + 60);
    rreg(8'h01);
    chk(rd, 8'h80, "power-on only");
    finish_test();
  end
endmodule
